// ### hw/ialc_gain_ctrl.sv
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
// Operation
// - With the limiter mode selected the loop sees peaks above the threshold and pulls gain down.
// - In limiter mode gain climbs back slowly to the static setting and never above it.
// - With level control selected the loop steers gain so the ADC level sits at the target.
// - The loop acts only while the enable bit 8 of the first register is set, reset clear.
// - The 4-bit target runs from -28.5dB FS in 1.5dB steps to -6dB FS, reset 1011.
// - The ceiling field in bits 5:3 caps gain from -6.75dB to +35.25dB in 6dB steps, reset 111.
// - The floor field in bits 2:0 limits gain from -12dB to +30dB in 6dB steps, reset 000.
// - Before gain rises the loop waits the hold delay of bits 7:4, 2.67ms doubling per code.
// - The hold delay is skipped entirely in limiter mode.
// - Gain starts to fall at once when the level goes over target, with no hold.
// - In level control the rise rate runs from 3.3ms to 3.36s per 6dB in powers of two.
// - In level control the fall rate runs from 832us to 852ms per 6dB in powers of two.
// - In limiter mode both ramp rates run about four times faster.
// - Timing follows the configured sample rate, so software must set it to the real rate.
// - Bit 8 of the second register makes gain changes wait for a zero crossing, reset off.
module ialc_gain_ctrl
  import ialc_pkg::*;
(
  input  wire logic                sys_clk,
  input  wire logic                resetn,
  input  wire logic [ADDR_W-1:0]   regAddr,
  input  wire logic [DATA_W-1:0]   regWrData,
  input  wire logic                regWrEn,
  input  wire logic                regRdEn,
  output logic      [DATA_W-1:0]   regRdData,
  input  wire logic                adcValid,
  input  wire logic [SAMPLE_W-1:0] adcSample,
  input  wire logic [GAIN_W-1:0]   pgaStaticGain,
  output logic      [GAIN_W-1:0]   pgaGain,
  output logic                     loopActive
);

  ialc_config_type    cfg_reg;
  ialc_config_type    cfg_next;
  ialc_state_type     state_reg;
  ialc_state_type     state_next;
  logic [GAIN_W-1:0]  work_reg;
  logic [GAIN_W-1:0]  work_next;
  logic [GAIN_W-1:0]  pgaGain_reg;
  logic [GAIN_W-1:0]  pgaGain_next;
  logic               pending_reg;
  logic               pending_next;
  logic [DATA_W-1:0]  rdData_reg;
  logic [DATA_W-1:0]  rdData_next;
  logic               active_reg;
  logic [LEVEL_W-1:0] peakLevel;
  logic               zeroCross;
  logic               timerExpired;
  logic               restartTimer;
  logic               clearPeak;

  // Register decode
  wire selOne   = (regAddr == REG_CFG_ONE_ADDR);
  wire selTwo   = (regAddr == REG_CFG_TWO_ADDR);
  wire selThree = (regAddr == REG_CFG_THREE_ADDR);
  wire selSrate = (regAddr == REG_SRATE_ADDR);
  wire selStat  = (regAddr == REG_STATUS_ADDR);

  // Write path; other addresses, the status word included, ignore writes
  always_comb begin
    cfg_next = cfg_reg;
    if (regWrEn && selOne) begin
      cfg_next.enable  = regWrData[ENABLE_BIT];
      cfg_next.ceiling = regWrData[CEIL_LSB +: 3];
      cfg_next.floor   = regWrData[FLOOR_LSB +: 3];
    end
    if (regWrEn && selTwo) begin
      cfg_next.zcUpdate = regWrData[ZC_BIT];
      cfg_next.hold     = regWrData[HOLD_LSB +: 4];
      cfg_next.target   = regWrData[TARGET_LSB +: 4];
    end
    if (regWrEn && selThree) begin
      cfg_next.limiterMode = regWrData[MODE_BIT];
      cfg_next.rampup      = regWrData[RAMPUP_LSB +: 4];
      cfg_next.rampdown    = regWrData[RAMPDOWN_LSB +: 4];
    end
    if (regWrEn && selSrate) begin
      cfg_next.sampleRate = regWrData[SRATE_LSB +: 3];
    end
  end

  // Read words, built from the stored fields
  wire [DATA_W-1:0] wordOne = {cfg_reg.enable, 2'h0, cfg_reg.ceiling, cfg_reg.floor};
  wire [DATA_W-1:0] wordTwo = {cfg_reg.zcUpdate, cfg_reg.hold, cfg_reg.target};
  wire [DATA_W-1:0] wordThree = {cfg_reg.limiterMode, cfg_reg.rampup, cfg_reg.rampdown};
  wire [DATA_W-1:0] wordSrate = {6'h00, cfg_reg.sampleRate};
  // Status bit 8 shows a gain change still waiting for a zero crossing
  wire [DATA_W-1:0] wordStat  = {pending_reg, state_reg, work_reg};

  // Unmapped reads answer zero; data shows only in the cycle after the strobe
  assign rdData_next = !regRdEn ? {DATA_W{1'b0}} :
                       selOne   ? wordOne :
                       selTwo   ? wordTwo :
                       selThree ? wordThree :
                       selSrate ? wordSrate :
                       selStat  ? wordStat : {DATA_W{1'b0}};

  // Gain limits in 0.75dB codes
  wire [GAIN_W-1:0] floorGain = {cfg_reg.floor, 3'h0};
  wire [GAIN_W-1:0] ceilGain  = {cfg_reg.ceiling, 3'h0} | CEIL_OFFSET;
  // Limiter never climbs past the static gain
  wire [GAIN_W-1:0] upperGain = (cfg_reg.limiterMode && pgaStaticGain < ceilGain) ?
                                pgaStaticGain : ceilGain;
  // Ceiling wins if software sets the floor above it
  wire [GAIN_W-1:0] lowerGain = (floorGain > upperGain) ? upperGain : floorGain;
  wire              canRise   = (work_reg < upperGain);
  wire              canFall   = (work_reg > lowerGain);
  wire [GAIN_W-1:0] gainUp    = work_reg + 6'h01;
  wire [GAIN_W-1:0] gainDown  = work_reg - 6'h01;
  wire [GAIN_W-1:0] gainClamp = (work_reg > upperGain) ? upperGain :
                                (work_reg < lowerGain) ? lowerGain : work_reg;

  // Peak over the target; the same threshold serves both modes
  wire [LEVEL_W-1:0] threshold = target_threshold(cfg_reg.target);
  wire               overNow   = (peakLevel > threshold);

  // Rate codes above ten act as ten
  wire [3:0] upCode   = (cfg_reg.rampup > RATE_CODE_MAX) ? RATE_CODE_MAX : cfg_reg.rampup;
  wire [3:0] downCode = (cfg_reg.rampdown > RATE_CODE_MAX) ? RATE_CODE_MAX : cfg_reg.rampdown;
  wire [3:0] holdShift = cfg_reg.hold - 4'h1;
  wire [TIMER_W-1:0] decayBase  = TIMER_W'(DECAY_UNITS);
  wire [TIMER_W-1:0] attackBase = TIMER_W'(ATTACK_UNITS);
  wire [TIMER_W-1:0] holdBase   = TIMER_W'(HOLD_UNITS);
  wire [TIMER_W-1:0] decayFull  = decayBase << upCode;
  wire [TIMER_W-1:0] attackFull = attackBase << downCode;
  // Limiter divides both rates by four for fast peak reduction
  wire [TIMER_W-1:0] decayIvl   = cfg_reg.limiterMode ?
                                  (decayFull >> LIMITER_SPEED_SHIFT) : decayFull;
  wire [TIMER_W-1:0] attackIvl  = cfg_reg.limiterMode ?
                                  (attackFull >> LIMITER_SPEED_SHIFT) : attackFull;
  wire [TIMER_W-1:0] holdIvl    = holdBase << holdShift;
  // Zero hold code, or limiter mode, means no wait at all
  wire               skipHold   = cfg_reg.limiterMode || (cfg_reg.hold == 4'h0);
  wire [TIMER_W-1:0] interval   = (state_reg == ST_ATTACK) ? attackIvl :
                                  (state_reg == ST_HOLD)   ? holdIvl : decayIvl;
  // Timer units per sample follow the configured rate, not the real one
  wire [INC_W-1:0]   sampleInc  = srate_inc(cfg_reg.sampleRate);

  ialc_peak_detect u_peak (
    .sys_clk     (sys_clk),
    .resetn      (resetn),
    .sampleValid (adcValid),
    .sample      (adcSample),
    .clearPeak   (clearPeak),
    .peakLevel   (peakLevel),
    .zeroCross   (zeroCross)
  );

  ialc_step_timer u_timer (
    .sys_clk     (sys_clk),
    .resetn      (resetn),
    .restart     (restartTimer),
    .sampleValid (adcValid),
    .inc         (sampleInc),
    .interval    (interval),
    .expired     (timerExpired)
  );

  // Loop sequencer: a peak over target takes priority in the hold and decay states
  always_comb begin
    state_next   = state_reg;
    work_next    = work_reg;
    restartTimer = 1'b0;
    clearPeak    = 1'b0;
    case (state_reg)
      ST_OFF: begin
        work_next = pgaStaticGain;
        if (cfg_reg.enable) begin
          state_next   = skipHold ? ST_DECAY : ST_HOLD;
          restartTimer = 1'b1;
          clearPeak    = 1'b1;
        end
      end
      ST_HOLD: begin
        work_next = gainClamp;
        if (overNow) begin
          // First step down happens at once, no hold before it
          state_next   = ST_ATTACK;
          work_next    = canFall ? gainDown : gainClamp;
          restartTimer = 1'b1;
          clearPeak    = 1'b1;
        end else if (skipHold || timerExpired) begin
          state_next   = ST_DECAY;
          restartTimer = 1'b1;
        end
      end
      ST_DECAY: begin
        work_next = gainClamp;
        if (overNow) begin
          state_next   = ST_ATTACK;
          work_next    = canFall ? gainDown : gainClamp;
          restartTimer = 1'b1;
          clearPeak    = 1'b1;
        end else if (timerExpired && canRise) begin
          // Level under target: one step up per decay interval
          work_next    = gainUp;
          restartTimer = 1'b1;
          clearPeak    = 1'b1;
        end
      end
      ST_ATTACK: begin
        work_next = gainClamp;
        if (timerExpired) begin
          restartTimer = 1'b1;
          clearPeak    = 1'b1;
          if (overNow) begin
            work_next = canFall ? gainDown : gainClamp;
          end else begin
            state_next = skipHold ? ST_DECAY : ST_HOLD;
          end
        end
      end
      default: begin
        state_next = ST_OFF;
        work_next  = pgaStaticGain;
      end
    endcase
    if (!cfg_reg.enable) begin
      // Disabled: gain returns to the static setting straight away
      state_next = ST_OFF;
      work_next  = pgaStaticGain;
    end
  end

  // Output gain follows the working gain, or waits for a zero crossing.
  // A change that never meets a crossing, e.g. on DC input, stays pending.
  wire changed = (work_reg != pgaGain_reg);
  wire applyNow = !cfg_reg.enable || !cfg_reg.zcUpdate || zeroCross;
  // Disabled: a pending loop gain is dropped, never flashed onto the amplifier
  assign pgaGain_next = !cfg_reg.enable       ? pgaStaticGain :
                        (changed && applyNow) ? work_reg : pgaGain_reg;
  assign pending_next = changed && !applyNow;

  // Configuration flip-flops
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cfg_reg.enable      <= ENABLE_RST;
      cfg_reg.ceiling     <= CEIL_RST;
      cfg_reg.floor       <= FLOOR_RST;
      cfg_reg.zcUpdate    <= ZC_RST;
      cfg_reg.hold        <= HOLD_RST;
      cfg_reg.target      <= TARGET_RST;
      cfg_reg.limiterMode <= MODE_RST;
      cfg_reg.rampup      <= RAMPUP_RST;
      cfg_reg.rampdown    <= RAMPDOWN_RST;
      cfg_reg.sampleRate  <= SRATE_RST;
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  // Loop state; gain leaves reset at the lowest code until enabled or tracked
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg   <= ST_OFF;
      work_reg    <= 6'h00;
      pgaGain_reg <= 6'h00;
      pending_reg <= 1'b0;
    end else begin
      state_reg   <= state_next;
      work_reg    <= work_next;
      pgaGain_reg <= pgaGain_next;
      pending_reg <= pending_next;
    end
  end

  // Registered outputs
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rdData_reg <= {DATA_W{1'b0}};
      active_reg <= 1'b0;
    end else begin
      rdData_reg <= rdData_next;
      active_reg <= (state_next != ST_OFF);
    end
  end

  assign regRdData  = rdData_reg;
  assign pgaGain    = pgaGain_reg;
  assign loopActive = active_reg;

endmodule : ialc_gain_ctrl

// ### pkg/ialc_pkg.sv
package ialc_pkg;

  // Port and datapath widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 9;
  localparam int GAIN_W = 6;
  localparam int SAMPLE_W = 16;
  localparam int LEVEL_W = 15;
  localparam int TIMER_W = 24;
  localparam int INC_W = 5;

  // Register addresses
  localparam logic [ADDR_W-1:0] REG_CFG_ONE_ADDR   = 8'h20;
  localparam logic [ADDR_W-1:0] REG_CFG_TWO_ADDR   = 8'h21;
  localparam logic [ADDR_W-1:0] REG_CFG_THREE_ADDR = 8'h22;
  localparam logic [ADDR_W-1:0] REG_SRATE_ADDR     = 8'h23;
  localparam logic [ADDR_W-1:0] REG_STATUS_ADDR    = 8'h24;

  // Field positions
  localparam int ENABLE_BIT   = 8;
  localparam int CEIL_LSB     = 3;
  localparam int FLOOR_LSB    = 0;
  localparam int ZC_BIT       = 8;
  localparam int HOLD_LSB     = 4;
  localparam int TARGET_LSB   = 0;
  localparam int MODE_BIT     = 8;
  localparam int RAMPUP_LSB   = 4;
  localparam int RAMPDOWN_LSB = 0;
  localparam int SRATE_LSB    = 0;
  localparam int STAT_GAIN_LSB  = 0;
  localparam int STAT_STATE_LSB = 6;

  // Reset values
  localparam logic       ENABLE_RST   = 1'h0;
  localparam logic [2:0] CEIL_RST     = 3'h7;
  localparam logic [2:0] FLOOR_RST    = 3'h0;
  localparam logic       ZC_RST       = 1'h0;
  localparam logic [3:0] HOLD_RST     = 4'h0;
  localparam logic [3:0] TARGET_RST   = 4'hb;
  localparam logic       MODE_RST     = 1'h0;
  localparam logic [3:0] RAMPUP_RST   = 4'h3;
  localparam logic [3:0] RAMPDOWN_RST = 4'h2;
  localparam logic [2:0] SRATE_RST    = 3'h0;

  // Gain code: 0.75dB per step, code 0 is -12dB, eight steps per 6dB
  localparam int GAIN_6DB_SHIFT = 3;
  localparam logic [GAIN_W-1:0] CEIL_OFFSET = 6'h07;
  localparam logic [3:0] RATE_CODE_MAX = 4'ha;
  localparam int LIMITER_SPEED_SHIFT = 2;

  // Times in nanoseconds at 48 kHz; timers count quarter sample periods
  localparam int SAMPLE48_PS   = 20833;
  localparam int ATTACK_STEP_PS = 104000;
  localparam int DECAY_STEP_PS  = 410000;
  localparam int HOLD_BASE_PS   = 2670000;
  localparam int UNITS_PER_SAMPLE = 4;
  localparam int ATTACK_UNITS =
    (ATTACK_STEP_PS * UNITS_PER_SAMPLE + SAMPLE48_PS - 1) / SAMPLE48_PS;
  localparam int DECAY_UNITS =
    (DECAY_STEP_PS * UNITS_PER_SAMPLE + SAMPLE48_PS - 1) / SAMPLE48_PS;
  localparam int HOLD_UNITS =
    (HOLD_BASE_PS * UNITS_PER_SAMPLE + SAMPLE48_PS - 1) / SAMPLE48_PS;

  typedef enum logic [1:0] {ST_OFF, ST_HOLD, ST_DECAY, ST_ATTACK} ialc_state_type;

  typedef struct packed {
    logic       enable;
    logic [2:0] ceiling;
    logic [2:0] floor;
    logic       zcUpdate;
    logic [3:0] hold;
    logic [3:0] target;
    logic       limiterMode;
    logic [3:0] rampup;
    logic [3:0] rampdown;
    logic [2:0] sampleRate;
  } ialc_config_type;

  // Timer units added per real sample, from the configured rate
  function automatic logic [INC_W-1:0] srate_inc(input logic [2:0] code);
    case (code)
      3'h1: srate_inc = 5'h06;
      3'h2: srate_inc = 5'h08;
      3'h3: srate_inc = 5'h0c;
      3'h4: srate_inc = 5'h10;
      3'h5: srate_inc = 5'h18;
      default: srate_inc = 5'h04;
    endcase
  endfunction : srate_inc

  // Magnitude for -28.5dB FS plus 1.5dB per code
  function automatic logic [LEVEL_W-1:0] target_threshold(input logic [3:0] code);
    case (code)
      4'h0: target_threshold = 15'h04cf;
      4'h1: target_threshold = 15'h05b8;
      4'h2: target_threshold = 15'h06cc;
      4'h3: target_threshold = 15'h0814;
      4'h4: target_threshold = 15'h0999;
      4'h5: target_threshold = 15'h0b69;
      4'h6: target_threshold = 15'h0d8f;
      4'h7: target_threshold = 15'h101d;
      4'h8: target_threshold = 15'h1327;
      4'h9: target_threshold = 15'h16c3;
      4'ha: target_threshold = 15'h1b0d;
      4'hb: target_threshold = 15'h2027;
      4'hc: target_threshold = 15'h2635;
      4'hd: target_threshold = 15'h2d6a;
      4'he: target_threshold = 15'h35fa;
      default: target_threshold = 15'h4027;
    endcase
  endfunction : target_threshold

endpackage : ialc_pkg

// ### hw/ialc_peak_detect.sv
`timescale 1ns/1ps
module ialc_peak_detect
  import ialc_pkg::*;
(
  input  wire logic                sys_clk,
  input  wire logic                resetn,
  input  wire logic                sampleValid,
  input  wire logic [SAMPLE_W-1:0] sample,
  input  wire logic                clearPeak,
  output logic      [LEVEL_W-1:0]  peakLevel,
  output logic                     zeroCross
);
  logic [LEVEL_W-1:0] peak_reg;
  logic               sign_reg;
  logic               zc_reg;
  wire  [SAMPLE_W-1:0] negated  = SAMPLE_W'(~sample + 16'h0001);
  // Full-scale negative saturates so it is not read as zero
  wire  [LEVEL_W-1:0]  absLevel = !sample[SAMPLE_W-1] ? sample[LEVEL_W-1:0] :
                                  negated[SAMPLE_W-1] ? 15'h7fff : negated[LEVEL_W-1:0];
  wire  [LEVEL_W-1:0]  base     = clearPeak ? 15'h0000 : peak_reg;
  wire  [LEVEL_W-1:0]  peak_next = (sampleValid && absLevel > base) ? absLevel : base;
  wire                 zc_next  = sampleValid && (sample[SAMPLE_W-1] != sign_reg);

  // Peak holds the largest magnitude since the last clear
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      peak_reg <= 15'h0000;
      sign_reg <= 1'b0;
      zc_reg   <= 1'b0;
    end else begin
      peak_reg <= peak_next;
      zc_reg   <= zc_next;
      if (sampleValid) sign_reg <= sample[SAMPLE_W-1];
    end
  end

  assign peakLevel = peak_reg;
  assign zeroCross = zc_reg;
endmodule : ialc_peak_detect

// ### hw/ialc_step_timer.sv
`timescale 1ns/1ps
module ialc_step_timer
  import ialc_pkg::*;
(
  input  wire logic               sys_clk,
  input  wire logic               resetn,
  input  wire logic               restart,
  input  wire logic               sampleValid,
  input  wire logic [INC_W-1:0]   inc,
  input  wire logic [TIMER_W-1:0] interval,
  output logic                    expired
);
  logic [TIMER_W-1:0] elapsed_reg;
  // One extra bit catches the wrap so the count saturates
  wire  [TIMER_W:0]   sum = {1'b0, elapsed_reg} + {{(TIMER_W+1-INC_W){1'b0}}, inc};
  wire  [TIMER_W-1:0] elapsed_next = restart ? {TIMER_W{1'b0}} :
                                     !sampleValid ? elapsed_reg :
                                     sum[TIMER_W] ? {TIMER_W{1'b1}} : sum[TIMER_W-1:0];

  // Elapsed time advances per real sample, weighted by the configured rate
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) elapsed_reg <= {TIMER_W{1'b0}};
    else         elapsed_reg <= elapsed_next;
  end

  assign expired = (elapsed_reg >= interval);
endmodule : ialc_step_timer

// ### verification/ialc_gain_ctrl_monitor.sv
`timescale 1ns/1ps
module ialc_gain_ctrl_monitor
  import ialc_pkg::*;
(
  input wire logic                sys_clk,
  input wire logic                resetn,
  input wire logic [ADDR_W-1:0]   regAddr,
  input wire logic [DATA_W-1:0]   regWrData,
  input wire logic                regWrEn,
  input wire logic                regRdEn,
  input wire logic [DATA_W-1:0]   regRdData,
  input wire logic                adcValid,
  input wire logic [SAMPLE_W-1:0] adcSample,
  input wire logic [GAIN_W-1:0]   pgaStaticGain,
  input wire logic [GAIN_W-1:0]   pgaGain,
  input wire logic                loopActive
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  // Read port and register map
  AST_RD_IDLE_ZERO: assert property (!$past(regRdEn) |-> regRdData == '0)
    else $error("read data not zero outside read slot");
  AST_UNMAPPED_ZERO: assert property (regRdEn && regAddr > REG_STATUS_ADDR |=> regRdData == '0)
    else $error("unmapped read not zero");
  AST_CFG_ONE_BACK: assert property (regWrEn && regAddr == REG_CFG_ONE_ADDR ##1
    regRdEn && regAddr == REG_CFG_ONE_ADDR |=> regRdData == ($past(regWrData, 2) & 9'h13f))
    else $error("first config readback wrong");
  AST_CFG_TWO_BACK: assert property (regWrEn && regAddr == REG_CFG_TWO_ADDR ##1
    regRdEn && regAddr == REG_CFG_TWO_ADDR |=> regRdData == $past(regWrData, 2))
    else $error("second config readback wrong");

  // Enable bit starts and stops the loop
  AST_LOOP_ON: assert property (regWrEn && regAddr == REG_CFG_ONE_ADDR && regWrData[ENABLE_BIT]
    |-> ##[1:2] loopActive) else $error("loop did not start");
  AST_LOOP_OFF: assert property (regWrEn && regAddr == REG_CFG_ONE_ADDR && !regWrData[ENABLE_BIT]
    |-> ##[1:2] !loopActive) else $error("loop did not stop");
  AST_STATIC_FOLLOW: assert property (resetn && !loopActive ##1 !loopActive
    |-> pgaGain == $past(pgaStaticGain)) else $error("idle gain not static gain");

  // Loop moves gain one code at a time, only after a sample
  AST_ONE_STEP: assert property (loopActive && $past(loopActive) && $changed(pgaGain)
    |-> pgaGain == GAIN_W'($past(pgaGain) + 1) || pgaGain == GAIN_W'($past(pgaGain) - 1))
    else $error("gain moved more than one code");
  AST_STEP_AFTER_SAMPLE: assert property (loopActive && $past(loopActive) && $changed(pgaGain)
    |-> $past(adcValid) || $past(adcValid, 2) || $past(adcValid, 3))
    else $error("gain moved without a sample");

  COV_LOOP_ON: cover property ($rose(loopActive));
  COV_STEP: cover property (loopActive && $changed(pgaGain));
  COV_LOOP_OFF: cover property ($fell(loopActive));
endmodule : ialc_gain_ctrl_monitor

// ### verification/ialc_pga_adc_model.sv
`timescale 1ns/1ps
// Amplifier and converter seen from the loop; the level is set by the bench and the
// gain is not folded back, so the loop is tested open, a limitation accepted for size
module ialc_pga_adc_model
  import ialc_pkg::*;
(
  input  wire logic                sys_clk,
  input  wire logic                resetn,
  input  wire logic [SAMPLE_W-1:0] level,
  output logic                     adcValid,
  output logic      [SAMPLE_W-1:0] adcSample
);
  logic [1:0] phaseCnt;
  logic       signFlag;

  // One sample every four clocks whatever rate is configured; sign alternates each sample
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      phaseCnt  <= 2'h0;
      signFlag  <= 1'b0;
      adcValid  <= 1'b0;
      adcSample <= 16'h0000;
    end else begin
      phaseCnt <= phaseCnt + 2'h1;
      adcValid <= (phaseCnt == 2'h3);
      if (phaseCnt == 2'h3) begin
        signFlag  <= ~signFlag;
        adcSample <= signFlag ? -level : level;
      end else begin
        adcSample <= ~adcSample; // Not valid between samples, so never hold the old value
      end
    end
  end
endmodule : ialc_pga_adc_model

// ### verification/ialc_gain_ctrl_tb.sv
`timescale 1ns/1ps
module ialc_gain_ctrl_tb;
  import ialc_pkg::*;
  logic                sys_clk       = 1'b0;
  logic                resetn        = 1'b0;
  logic [ADDR_W-1:0]   regAddr       = '0;
  logic [DATA_W-1:0]   regWrData     = '0;
  logic                regWrEn       = 1'b0;
  logic                regRdEn       = 1'b0;
  logic [DATA_W-1:0]   regRdData;
  logic                adcValid;
  logic [SAMPLE_W-1:0] adcSample;
  logic [SAMPLE_W-1:0] level         = 16'h0100;
  logic [GAIN_W-1:0]   pgaStaticGain = 6'h28;
  logic [GAIN_W-1:0]   pgaGain;
  logic                loopActive;
  int                  n_fail        = 0;
  int                  cmp_count     = 0;

  always #2.5 sys_clk = ~sys_clk;

  ialc_gain_ctrl u_ialc_gain_ctrl (.sys_clk(sys_clk), .resetn(resetn), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .adcValid(adcValid), .adcSample(adcSample), .pgaStaticGain(pgaStaticGain),
    .pgaGain(pgaGain), .loopActive(loopActive));
  ialc_pga_adc_model u_ialc_pga_adc_model (.sys_clk(sys_clk), .resetn(resetn), .level(level),
    .adcValid(adcValid), .adcSample(adcSample));

  task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Callers start right after a rising edge; a write leaves no gap so a read can follow
  task automatic wr(input logic [7:0] a, input logic [8:0] d);
    regAddr   <= a;
    regWrData <= d;
    regWrEn   <= 1'b1;
    @(posedge sys_clk);
    regWrEn <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [8:0] exp, input string what);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge sys_clk);
    regRdEn <= 1'b0;
    #1 chk(what, exp, regRdData);
    @(posedge sys_clk);
  endtask : rd

  // Gain is sampled on the falling edge, away from its update
  task automatic wait_gain(input logic [5:0] exp, input int bound);
    int i;
    @(negedge sys_clk);
    for (i = 0; i < bound && pgaGain !== exp; i++) @(negedge sys_clk);
    chk("pgaGain", {3'h0, exp}, {3'h0, pgaGain});
    if (i == bound) stop_test();
    @(posedge sys_clk);
  endtask : wait_gain

  task automatic settle(input logic [5:0] exp, input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
    chk("pgaGain", {3'h0, exp}, {3'h0, pgaGain});
    @(posedge sys_clk);
  endtask : settle

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test

  // Main sequence
  initial begin
    repeat (5) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    rd(REG_CFG_ONE_ADDR, 9'h038, "cfgOne");
    rd(REG_CFG_TWO_ADDR, 9'h00b, "cfgTwo");
    rd(REG_CFG_THREE_ADDR, 9'h032, "cfgThree");
    rd(REG_SRATE_ADDR, 9'h000, "sampleRate");
    rd(8'h30, 9'h000, "unmapped");
    settle(6'h28, 1);
    $display("test reset values done");
    wr(REG_CFG_THREE_ADDR, 9'h000);
    rd(REG_CFG_THREE_ADDR, 9'h000, "cfgThree");
    wr(REG_CFG_TWO_ADDR, 9'h01b);
    rd(REG_CFG_TWO_ADDR, 9'h01b, "cfgTwo");
    level <= 16'h4000;
    wr(REG_CFG_ONE_ADDR, 9'h13a);
    rd(REG_CFG_ONE_ADDR, 9'h13a, "cfgOne");
    wait_gain(6'h10, 2000);
    settle(6'h10, 200);
    $display("test level control attack done");
    level <= 16'h0100;
    wr(REG_CFG_ONE_ADDR, 9'h11a);
    rd(REG_CFG_ONE_ADDR, 9'h11a, "cfgOne");
    settle(6'h10, 400);
    wait_gain(6'h1f, 3000);
    $display("test level control hold and decay done");
    wr(REG_CFG_ONE_ADDR, 9'h03a);
    rd(REG_CFG_ONE_ADDR, 9'h03a, "cfgOne");
    pgaStaticGain <= 6'h30;
    settle(6'h30, 2);
    wr(REG_CFG_THREE_ADDR, 9'h100);
    rd(REG_CFG_THREE_ADDR, 9'h100, "cfgThree");
    level <= 16'h4000;
    wr(REG_CFG_ONE_ADDR, 9'h13a);
    rd(REG_CFG_ONE_ADDR, 9'h13a, "cfgOne");
    wait_gain(6'h10, 400);
    level <= 16'h0100;
    wait_gain(6'h11, 100);
    wait_gain(6'h30, 1000);
    settle(6'h30, 300);
    $display("test limiter done");
    wr(REG_CFG_ONE_ADDR, 9'h03a);
    rd(REG_CFG_ONE_ADDR, 9'h03a, "cfgOne");
    wr(REG_CFG_THREE_ADDR, 9'h000);
    rd(REG_CFG_THREE_ADDR, 9'h000, "cfgThree");
    wr(REG_CFG_TWO_ADDR, 9'h10b);
    rd(REG_CFG_TWO_ADDR, 9'h10b, "cfgTwo");
    wr(REG_SRATE_ADDR, 9'h003);
    rd(REG_SRATE_ADDR, 9'h003, "sampleRate");
    level <= 16'h0000;
    wr(REG_CFG_ONE_ADDR, 9'h13a);
    rd(REG_CFG_ONE_ADDR, 9'h13a, "cfgOne");
    // Silent input never crosses zero, so the rising loop gain must stay pending
    settle(6'h30, 700);
    // The 16k rate code triples the timer step, so the ceiling is reached by now, unlike at the default rate
    rd(REG_STATUS_ADDR, 9'h1bf, "status");
    wr(REG_CFG_ONE_ADDR, 9'h03a);
    settle(6'h30, 2);
    $display("test zero cross and sample rate done");
    stop_test();
  end

  // Hang guard
  initial begin
    repeat (100000) @(posedge sys_clk);
    n_fail++;
    stop_test();
  end
endmodule : ialc_gain_ctrl_tb

bind ialc_gain_ctrl ialc_gain_ctrl_monitor u_ialc_gain_ctrl_monitor (.sys_clk(sys_clk),
  .resetn(resetn), .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
  .regRdEn(regRdEn), .regRdData(regRdData), .adcValid(adcValid), .adcSample(adcSample),
  .pgaStaticGain(pgaStaticGain), .pgaGain(pgaGain), .loopActive(loopActive));
